// [logic/spz_regs.vh]
// Summary of operation
// - Relay energizes above setpoint in high mode, below it in low mode.
// - Activation pattern has four characters, setpoint one to four left to right.
// - Advance moves to next pattern character; up/down toggle low and high.
// - Single-colour bargraph: after fourth character, return to operating display.
// - Tricolour bargraph: after fourth character, enter colour programming.
// - Bargraph lights exactly one colour at a time.
// - Entering a new zone switches the whole bar to that zone's colour.
// - Below the lowest setpoint, show the below-lowest colour.
// - Above a setpoint show its colour; zones follow values, not numbering.
// - Equal setpoints: the highest-numbered setpoint's colour wins.
// - Each colour selectable with up/down among green, orange and red.
// - Colour steps: below-lowest, then setpoints one to four; then exit.
// - Setpoint four has value and hysteresis only, then pattern editor.
// - While dim is asserted, drive displays at half selected brightness.
// - While lock is asserted, parameters may be viewed but not changed.
// - All four comparisons exist regardless of fitted relay count.
`ifndef SPZ_REGS_VH
`define SPZ_REGS_VH
`define SPZ_DATA_W 16
`define SPZ_NUM_SP 4
`define SPZ_COL_GREEN 2'h0
`define SPZ_COL_ORANGE 2'h1
`define SPZ_COL_RED 2'h2
`define SPZ_COL_RST 2'h0
`define SPZ_SP_RST 16'h0000
`define SPZ_PAT_RST 4'hF
`define SPZ_HYS_RST 4'h0
`define SPZ_BRIGHT_W 2
`define SPZ_STEP_W 5
`endif

// [logic/spz_sync.v]
`timescale 1ns/1ps
module spz_sync (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Data
   input wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg sync_q;
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         // Rear pins idle high: no false dim or lock right after reset
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule // spz_sync

// [logic/spz_zone_color.v]
`timescale 1ns/1ps
`include "spz_regs.vh"
module spz_zone_color (
   // Reading and setpoints
   input wire [`SPZ_DATA_W-1:0] reading,
   input wire [4*`SPZ_DATA_W-1:0] sp_flat,
   // Colours
   input wire [1:0] color_below,
   input wire [7:0] color_above,
   // Result
   output reg [1:0] zone_color
);
   integer i;
   reg signed [`SPZ_DATA_W-1:0] best;
   reg signed [`SPZ_DATA_W-1:0] spv;
   reg found;
   // Highest setpoint strictly below reading picks zone; equal value: later index wins
   always @* begin
      zone_color = color_below;
      best = {`SPZ_DATA_W{1'b0}};
      spv = {`SPZ_DATA_W{1'b0}};
      found = 1'b0;
      for (i = 0; i < `SPZ_NUM_SP; i = i + 1) begin
         spv = sp_flat[i*`SPZ_DATA_W +: `SPZ_DATA_W];
         if ($signed(reading) > spv) begin
            if (!found || spv >= best) begin
               best = spv;
               found = 1'b1;
               zone_color = color_above[i*2 +: 2];
            end
         end
      end
   end
endmodule // spz_zone_color

// [logic/spz_setpoint_ctrl.v]
`timescale 1ns/1ps
`include "spz_regs.vh"
module spz_setpoint_ctrl (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Measurement
   input wire [`SPZ_DATA_W-1:0] reading,
   // Front panel buttons, one-cycle pulses from debounce logic; display_blank is a held level
   input wire btn_prog,
   input wire btn_up,
   input wire btn_down,
   input wire btn_enter_sp,
   input wire display_blank,
   // Build options
   input wire tricolor_fitted,
   // Rear panel pins, low when shorted to common
   input wire dim_in_n,
   input wire lock_in_n,
   // Brightness
   input wire [`SPZ_BRIGHT_W-1:0] brightness_sel,
   output reg [`SPZ_BRIGHT_W+1:0] bright_level,
   // Relays and annunciators
   output reg [3:0] relay_on,
   output reg [3:0] annunciator,
   // Bargraph
   output reg bar_red,
   output reg bar_green,
   // Programming view
   output reg [`SPZ_STEP_W-1:0] prog_step,
   output reg [1:0] pattern_digit,
   output reg prog_active,
   output reg [3:0] relay_activation_pattern
);
   // ----------------------------------------
   // Step codes, one-hot
   // ----------------------------------------
   localparam [`SPZ_STEP_W-1:0] ST_IDLE = 5'h01;
   localparam [`SPZ_STEP_W-1:0] ST_SP = 5'h02;
   localparam [`SPZ_STEP_W-1:0] ST_HYS = 5'h04;
   localparam [`SPZ_STEP_W-1:0] ST_PAT = 5'h08;
   localparam [`SPZ_STEP_W-1:0] ST_COL = 5'h10;

   // ----------------------------------------
   // Rear input synchronisers
   // ----------------------------------------
   wire dim_n_s;
   wire lock_n_s;
   spz_sync u_dim (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(dim_in_n),
      .sync_out(dim_n_s)
   );
   spz_sync u_lock (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(lock_in_n),
      .sync_out(lock_n_s)
   );
   wire dim_on = ~dim_n_s;
   wire locked = ~lock_n_s;

   // ----------------------------------------
   // Stored settings
   // ----------------------------------------
   reg [`SPZ_DATA_W-1:0] sp_q [0:3];
   reg [3:0] hysteresis_select_q;
   reg [3:0] pat_q;
   reg [1:0] color_below_q;
   reg [7:0] color_above_q;
   reg [`SPZ_STEP_W-1:0] step_q;
   reg [2:0] idx_q;
   wire [3:0] act_d;

   function [1:0] col_up;
      input [1:0] c;
      begin
         col_up = (c == `SPZ_COL_RED) ? `SPZ_COL_GREEN : c + 2'h1;
      end
   endfunction
   function [1:0] col_dn;
      input [1:0] c;
      begin
         col_dn = (c == `SPZ_COL_GREEN) ? `SPZ_COL_RED : c - 2'h1;
      end
   endfunction

   wire edit_ok = ~locked & ~display_blank;
   wire upd = btn_up | btn_down;
   wire [1:0] cur_col = (idx_q == 3'h0) ? color_below_q : color_above_q[(idx_q - 3'h1)*2 +: 2];
   wire [1:0] new_col = btn_up ? col_up(cur_col) : col_dn(cur_col);

   // ----------------------------------------
   // Programming sequence
   // ----------------------------------------
   integer k;
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         step_q <= ST_IDLE;
         idx_q <= 3'h0;
         pat_q <= `SPZ_PAT_RST;
         hysteresis_select_q <= `SPZ_HYS_RST;
         color_below_q <= `SPZ_COL_RST;
         color_above_q <= {4{`SPZ_COL_RST}};
         for (k = 0; k < 4; k = k + 1)
            sp_q[k] <= `SPZ_SP_RST;
      end else begin
         case (step_q)
            ST_IDLE: begin
               if (btn_enter_sp) begin
                  step_q <= ST_SP;
                  idx_q <= 3'h0;
               end
            end
            ST_SP: begin
               if (upd && edit_ok)
                  sp_q[idx_q[1:0]] <= btn_up ? sp_q[idx_q[1:0]] + 16'h0001 : sp_q[idx_q[1:0]] - 16'h0001;
               if (btn_prog)
                  step_q <= ST_HYS;
            end
            ST_HYS: begin
               if (upd && edit_ok)
                  hysteresis_select_q[idx_q[1:0]] <= ~hysteresis_select_q[idx_q[1:0]];
               if (btn_prog) begin
                  if (idx_q == 3'h3) begin
                     step_q <= ST_PAT;
                     idx_q <= 3'h0;
                  end else begin
                     step_q <= ST_SP;
                     idx_q <= idx_q + 3'h1;
                  end
               end
            end
            ST_PAT: begin
               if (upd && edit_ok)
                  pat_q[idx_q[1:0]] <= ~pat_q[idx_q[1:0]];
               if (btn_prog) begin
                  if (idx_q == 3'h3) begin
                     idx_q <= 3'h0;
                     step_q <= tricolor_fitted ? ST_COL : ST_IDLE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                  end
               end
            end
            ST_COL: begin
               if (upd && edit_ok) begin
                  if (idx_q == 3'h0)
                     color_below_q <= new_col;
                  else
                     color_above_q[(idx_q - 3'h1)*2 +: 2] <= new_col;
               end
               if (btn_prog) begin
                  if (idx_q == 3'h4) begin
                     step_q <= ST_IDLE;
                     idx_q <= 3'h0;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                  end
               end
            end
            default: begin
               step_q <= ST_IDLE;
               idx_q <= 3'h0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Comparisons, one per setpoint
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_cmp
         // Bit one of pattern means high activation
         assign act_d[g] = pat_q[g] ? ($signed(reading) > $signed(sp_q[g]))
                                    : ($signed(reading) < $signed(sp_q[g]));
      end
   endgenerate

   // ----------------------------------------
   // Zone colour
   // ----------------------------------------
   wire [1:0] zone_col;
   spz_zone_color u_zone (
      .reading(reading),
      .sp_flat({sp_q[3], sp_q[2], sp_q[1], sp_q[0]}),
      .color_below(color_below_q),
      .color_above(color_above_q),
      .zone_color(zone_col)
   );

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         relay_on <= 4'h0;
         annunciator <= 4'h0;
         bar_red <= 1'b0;
         bar_green <= 1'b0;
         bright_level <= {(`SPZ_BRIGHT_W+2){1'b0}};
         prog_step <= ST_IDLE;
         pattern_digit <= 2'h0;
         prog_active <= 1'b0;
         relay_activation_pattern <= `SPZ_PAT_RST;
      end else begin
         relay_on <= act_d;
         annunciator <= act_d;
         // Orange is red plus green over the whole bar: one colour only
         bar_red <= (zone_col != `SPZ_COL_GREEN);
         bar_green <= (zone_col != `SPZ_COL_RED);
         // Level in half steps: full setting is twice the code plus two, up to eight
         bright_level <= dim_on ? {2'b00, brightness_sel} + 4'h1
                                : {1'b0, brightness_sel, 1'b0} + 4'h2;
         prog_step <= step_q;
         pattern_digit <= idx_q[1:0];
         prog_active <= (step_q != ST_IDLE);
         relay_activation_pattern <= pat_q;
      end
   end
endmodule // spz_setpoint_ctrl

// [sim/spz_panel.sv]
`timescale 1ns/1ps
module spz_panel (
   // Clock
   input wire ref_clk,
   // Keys and rear pins
   output logic btn_prog,
   output logic btn_up,
   output logic btn_down,
   output logic btn_enter_sp,
   output logic dim_in_n,
   output logic lock_in_n
);
   initial begin
      {btn_prog, btn_up, btn_down, btn_enter_sp} = 4'h0;
      {dim_in_n, lock_in_n} = 2'h3;
   end
   // One-cycle key pulse per press, spaced so each step settles
   task press(input logic [3:0] k, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         {btn_prog, btn_up, btn_down, btn_enter_sp} <= k;
         @(posedge ref_clk);
         {btn_prog, btn_up, btn_down, btn_enter_sp} <= 4'h0;
         repeat (3) @(posedge ref_clk);
      end
   endtask
   // A closed switch ties the pin to common
   task rear(input logic dim_s, input logic lock_s);
      @(posedge ref_clk);
      dim_in_n <= !dim_s;
      lock_in_n <= !lock_s;
      repeat (5) @(posedge ref_clk);
      #1;
   endtask
endmodule // spz_panel

// [sim/spz_setpoint_ctrl_properties.sv]
`timescale 1ns/1ps
`include "spz_regs.vh"
module spz_setpoint_ctrl_props (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Controls
   input wire btn_prog,
   input wire display_blank,
   input wire tricolor_fitted,
   input wire dim_in_n,
   input wire lock_in_n,
   input wire [`SPZ_BRIGHT_W-1:0] brightness_sel,
   // Results
   input wire [`SPZ_BRIGHT_W+1:0] bright_level,
   input wire [3:0] relay_on,
   input wire [3:0] annunciator,
   input wire bar_red,
   input wire bar_green,
   input wire [`SPZ_STEP_W-1:0] prog_step,
   input wire [1:0] pattern_digit,
   input wire [3:0] relay_activation_pattern
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_hysteresis_select_last;
      prog_step == 5'h04 && pattern_digit == 2'h3 && btn_prog;
   endsequence
   sequence s_pat_last;
      prog_step == 5'h08 && pattern_digit == 2'h3 && btn_prog;
   endsequence
   AST_ANN_FOLLOW: assert property (annunciator == relay_on)
      else $error("annunciator differs from relay");
   AST_ONE_COLOUR: assert property ($past(rst_n) |-> (bar_red || bar_green))
      else $error("bar unlit");
   AST_DIM_HALF: assert property ((!dim_in_n && $stable(brightness_sel))[*5] |->
      bright_level == {2'b00, brightness_sel} + 4'h1) else $error("dim level wrong");
   AST_LOCK_HOLD: assert property ((!lock_in_n)[*5] |-> $stable(relay_activation_pattern))
      else $error("pattern changed while locked");
   AST_BLANK_HOLD: assert property (display_blank[*3] |-> $stable(relay_activation_pattern))
      else $error("pattern changed while blanked");
   AST_HYSTERESIS_SELECT_TO_PAT: assert property (s_hysteresis_select_last |-> ##2 prog_step == 5'h08)
      else $error("no pattern step after last hysteresis");
   AST_PAT_NEXT: assert property (prog_step == 5'h08 && pattern_digit != 2'h3 && btn_prog |->
      ##2 pattern_digit == $past(pattern_digit, 2) + 2'h1) else $error("pattern digit not advanced");
   AST_PAT_MONO: assert property (s_pat_last ##0 !tricolor_fitted |-> ##2 prog_step == 5'h01)
      else $error("mono unit not idle");
   AST_PAT_TRI: assert property (s_pat_last ##0 tricolor_fitted |-> ##2 prog_step == 5'h10)
      else $error("tricolour unit not in colour step");
endmodule // spz_setpoint_ctrl_props
bind spz_setpoint_ctrl spz_setpoint_ctrl_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .btn_prog(btn_prog),
   .display_blank(display_blank), .tricolor_fitted(tricolor_fitted), .dim_in_n(dim_in_n),
   .lock_in_n(lock_in_n), .brightness_sel(brightness_sel), .bright_level(bright_level), .relay_on(relay_on),
   .annunciator(annunciator), .bar_red(bar_red), .bar_green(bar_green), .prog_step(prog_step),
   .pattern_digit(pattern_digit), .relay_activation_pattern(relay_activation_pattern));

// [sim/spz_setpoint_ctrl_tb.sv]
`timescale 1ns/1ps
module spz_setpoint_ctrl_tb;
   localparam logic [3:0] ADV = 4'h8, UP = 4'h4, DN = 4'h2, ENT = 4'h1;
   logic ref_clk = 1'b0, rst_n = 1'b0, display_blank = 1'b0, tricolor_fitted = 1'b0;
   logic [15:0] reading = 16'h0000;
   logic [1:0] brightness_sel = 2'h2;
   wire btn_prog, btn_up, btn_down, btn_enter_sp, dim_in_n, lock_in_n, bar_red, bar_green, prog_active;
   wire [3:0] bright_level;
   wire [3:0] relay_on, annunciator, relay_activation_pattern;
   wire [4:0] prog_step;
   wire [1:0] pattern_digit;
   int err_total = 0, comparisons = 0, cyc = 0;
   always #4 ref_clk = ~ref_clk;
   spz_panel pnl (.ref_clk(ref_clk), .btn_prog(btn_prog), .btn_up(btn_up), .btn_down(btn_down),
      .btn_enter_sp(btn_enter_sp), .dim_in_n(dim_in_n), .lock_in_n(lock_in_n));
   spz_setpoint_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .reading(reading), .btn_prog(btn_prog),
      .btn_up(btn_up), .btn_down(btn_down), .btn_enter_sp(btn_enter_sp), .display_blank(display_blank),
      .tricolor_fitted(tricolor_fitted), .dim_in_n(dim_in_n), .lock_in_n(lock_in_n),
      .brightness_sel(brightness_sel), .bright_level(bright_level), .relay_on(relay_on),
      .annunciator(annunciator), .bar_red(bar_red), .bar_green(bar_green), .prog_step(prog_step),
      .pattern_digit(pattern_digit), .prog_active(prog_active),
      .relay_activation_pattern(relay_activation_pattern));
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Apply a reading, then compare relays, annunciators and bar colour
   task rd(input logic [15:0] r, input logic [7:0] rel, input logic [7:0] col);
      @(posedge ref_clk);
      reading <= r;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("relay", rel, {4'h0, relay_on});
      chk("annunciator", rel, {4'h0, annunciator});
      chk("bar", col, {6'h0, bar_red, bar_green});
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         test_done;
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("pattern", 8'h0F, {4'h0, relay_activation_pattern});
      chk("step", 8'h01, {3'h0, prog_step});
      chk("active", 8'h00, {7'h0, prog_active});
      rd(16'h0005, 8'h0F, 8'h01);
      rd(16'hFFFB, 8'h00, 8'h01);
      $display("test compare done");
      pnl.press(ENT, 1);
      chk("step", 8'h02, {3'h0, prog_step});
      chk("active", 8'h01, {7'h0, prog_active});
      pnl.press(UP, 10);
      pnl.press(ADV, 2);
      pnl.press(UP, 20);
      pnl.press(ADV, 2);
      pnl.press(UP, 20);
      pnl.press(ADV, 2);
      pnl.press(UP, 30);
      pnl.press(ADV, 2);
      chk("step", 8'h08, {3'h0, prog_step});
      pnl.press(DN, 1);
      pnl.press(ADV, 1);
      chk("digit", 8'h01, {6'h0, pattern_digit});
      pnl.press(ADV, 3);
      chk("step", 8'h01, {3'h0, prog_step});
      chk("active", 8'h00, {7'h0, prog_active});
      chk("pattern", 8'h0E, {4'h0, relay_activation_pattern});
      rd(16'h0005, 8'h01, 8'h01);
      rd(16'h0019, 8'h06, 8'h01);
      $display("test program done");
      pnl.rear(1'b0, 1'b1);
      pnl.press(ENT, 1);
      pnl.press(UP, 1);
      pnl.press(ADV, 8);
      pnl.press(UP, 1);
      pnl.rear(1'b0, 1'b0);
      @(posedge ref_clk);
      display_blank <= 1'b1;
      pnl.press(UP, 1);
      display_blank <= 1'b0;
      pnl.press(ADV, 4);
      chk("pattern", 8'h0E, {4'h0, relay_activation_pattern});
      rd(16'h000A, 8'h00, 8'h01);
      $display("test lock done");
      @(posedge ref_clk);
      tricolor_fitted <= 1'b1;
      pnl.press(ENT, 1);
      pnl.press(ADV, 12);
      chk("step", 8'h10, {3'h0, prog_step});
      pnl.press(UP, 1);
      pnl.press(ADV, 1);
      pnl.press(UP, 2);
      pnl.press(ADV, 2);
      pnl.press(UP, 1);
      pnl.press(ADV, 1);
      pnl.press(DN, 1);
      pnl.press(ADV, 1);
      chk("step", 8'h01, {3'h0, prog_step});
      rd(16'hFFFB, 8'h01, 8'h03);
      rd(16'h000F, 8'h00, 8'h02);
      rd(16'h0019, 8'h06, 8'h03);
      rd(16'h0023, 8'h0E, 8'h02);
      chk("bright", 8'h06, {4'h0, bright_level});
      pnl.rear(1'b1, 1'b0);
      chk("bright", 8'h03, {4'h0, bright_level});
      $display("test colour done");
      test_done;
   end
endmodule // spz_setpoint_ctrl_tb
